// ===== hdl/fctm_trip_mgr.sv
// trip manager top: trip ranking, reset policy, alarms, status and AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
module fctm_trip_mgr #(
   parameter logic [23:0] P_HOLD_CYC = fctm_pkg::HOLD_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic      [1:0]  o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic      [31:0] o_rdata,
   output logic      [1:0]  o_rresp,
   input  wire logic        i_trip_valid,
   input  wire logic [2:0]  i_trip_prio,
   input  wire logic [7:0]  i_trip_code,
   input  wire logic        i_supply_ok,
   input  wire logic        i_host_link_ok,
   input  wire logic        i_ribbon_conn,
   input  wire logic [7:0]  i_heatsink_temp,
   input  wire logic [15:0] i_diag_arm_v,
   input  wire logic [15:0] i_diag_flux_fb,
   input  wire logic [15:0] i_diag_field_i,
   input  wire logic [15:0] i_diag_fire_ang,
   input  wire logic [15:0] i_diag_flux_ref,
   output logic             o_field_en,
   output logic      [1:0]  o_left_disp,
   output logic      [7:0]  o_right_disp,
   output logic             o_alarm_hot,
   output logic             o_alarm_fail,
   output logic             o_host_link_lost_alarm,
   output logic             o_irq
);
   fctm_pkg::fctm_state_t s;
   fctm_pkg::fctm_state_t n;

   logic [2:0]       pin_s;
   logic             supply_s;
   logic             link_s;
   logic             ribbon_s;
   logic [31:0]      hist;
   logic [4:0][15:0] live;
   logic [4:0][15:0] view;
   logic             wr;
   logic [31:0]      wd;
   logic             cand_v;
   logic [2:0]       cand_prio;
   logic [7:0]       cand_code;
   logic             uv_pend;
   logic             accept;
   logic             rst_req;
   logic             rst_ok;
   logic             uv_clr;
   logic             clr;
   logic             def_req;
   logic             run_cond;
   logic [4:0]       ev;
   logic [4:0]       w1c;
   logic [31:0]      rd_val;
   logic             rd_ok;
   logic [2:0]       didx;

   // byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   fctm_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_pin   ({i_supply_ok, i_host_link_ok, i_ribbon_conn}),
      .o_sync  (pin_s)
   );
   assign supply_s = pin_s[2];
   assign link_s   = pin_s[1];
   assign ribbon_s = pin_s[0];

   fctm_hist u_hist (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_push  (accept),
      .i_code  (cand_code),
      .o_hist  (hist)
   );

   assign live = {i_diag_flux_ref, i_diag_fire_ang, i_diag_field_i, i_diag_flux_fb, i_diag_arm_v};
   assign view = s.tripped ? s.frz : live;

   ////////////////////////////////////////////////////////////////////////////////
   // trip candidate and reset policy
   always_comb begin
      uv_pend = !supply_s && !(s.tripped && (s.prio == fctm_pkg::PRIO_UV));
      if (uv_pend && (!i_trip_valid || (i_trip_prio >= fctm_pkg::PRIO_UV))) begin
         cand_prio = fctm_pkg::PRIO_UV;
         cand_code = fctm_pkg::CODE_UV;
      end else begin
         cand_prio = i_trip_prio;
         cand_code = i_trip_code;
      end
      cand_v  = uv_pend || i_trip_valid;
      accept  = cand_v && (!s.tripped || (cand_prio < s.prio));
      wr      = !s.awready && !s.wready && !s.bvalid;
      wd      = merge(32'h0, s.wdata, s.wstrb);
      rst_req = wr && (s.awaddr == fctm_pkg::REG_CMD) && wd[fctm_pkg::CMD_RESET];
      def_req = wr && (s.awaddr == fctm_pkg::REG_CODE) && (wd[7:0] == fctm_pkg::CODE_DEFAULTS);
      // hardware and undervoltage categories never take a user reset
      rst_ok  = s.tripped && (s.tmr >= P_HOLD_CYC)
                && ((s.prio == fctm_pkg::PRIO_NORM)
                    || ((s.prio == fctm_pkg::PRIO_EEF) && s.eef_ok));
      uv_clr  = s.tripped && (s.prio == fctm_pkg::PRIO_UV) && supply_s;
      clr     = !accept && ((rst_req && rst_ok) || uv_clr);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register read decode
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0;
      didx   = 3'((i_araddr - fctm_pkg::REG_DIAG0) >> 2);
      if (i_araddr == fctm_pkg::REG_CTRL) begin
         rd_val = {28'h0, s.host_run, s.mode, s.enable};
      end else if (i_araddr == fctm_pkg::REG_CODE || i_araddr == fctm_pkg::REG_CMD) begin
         rd_val = 32'h0;
      end else if (i_araddr == fctm_pkg::REG_STAT) begin
         rd_val = {13'h0, s.eef_ok, s.alarm_link, s.alarm_fail, s.alarm_hot, s.left,
                   s.field_en, s.code, s.prio, s.tripped};
      end else if (i_araddr == fctm_pkg::REG_IRQ) begin
         rd_val = {27'h0, s.irq_st};
      end else if (i_araddr == fctm_pkg::REG_MASK) begin
         rd_val = {27'h0, s.irq_mask};
      end else if (i_araddr == fctm_pkg::REG_HIST) begin
         rd_val = hist;
      end else if (i_araddr == fctm_pkg::REG_WARN) begin
         rd_val = {24'h0, s.warn_thr};
      end else if (i_araddr >= fctm_pkg::REG_DIAG0 && i_araddr <= fctm_pkg::REG_DIAG4
                   && i_araddr[1:0] == 2'h0) begin
         rd_val = {16'h0, view[didx]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n   = s;
      ev  = 5'h0;
      w1c = 5'h0;
      // write channel
      if (i_awvalid && s.awready) begin
         n.awready = 1'b0;
         n.awaddr  = i_awaddr;
      end
      if (i_wvalid && s.wready) begin
         n.wready = 1'b0;
         n.wdata  = i_wdata;
         n.wstrb  = i_wstrb;
      end
      if (s.bvalid && i_bready) begin
         n.bvalid  = 1'b0;
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end
      if (wr) begin
         n.bvalid = 1'b1;
         n.bresp  = fctm_pkg::RESP_OK;
         if (s.awaddr == fctm_pkg::REG_CTRL) begin
            {n.host_run, n.mode, n.enable} = 4'(merge({28'h0, s.host_run, s.mode, s.enable},
                                                s.wdata, s.wstrb));
         end else if (s.awaddr == fctm_pkg::REG_IRQ) begin
            w1c = wd[4:0];
         end else if (s.awaddr == fctm_pkg::REG_MASK) begin
            n.irq_mask = 5'(merge({27'h0, s.irq_mask}, s.wdata, s.wstrb));
         end else if (s.awaddr == fctm_pkg::REG_WARN) begin
            n.warn_thr = 8'(merge({24'h0, s.warn_thr}, s.wdata, s.wstrb));
         end else if (s.awaddr != fctm_pkg::REG_CODE && s.awaddr != fctm_pkg::REG_CMD) begin
            n.bresp = fctm_pkg::RESP_ERR;
         end
      end
      // read channel
      if (s.rvalid && i_rready) begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end
      if (i_arvalid && s.arready) begin
         n.arready = 1'b0;
         n.rvalid  = 1'b1;
         n.rdata   = rd_val;
         n.rresp   = rd_ok ? fctm_pkg::RESP_OK : fctm_pkg::RESP_ERR;
      end
      // defaults load from the code register while disabled; while enabled the fail alarm is raised instead
      if (def_req) begin
         if (s.enable) begin
            n.alarm_fail  = 1'b1;
            ev[fctm_pkg::IRQ_FAIL] = 1'b1;
         end else begin
            n.alarm_fail = 1'b0;
            n.mode       = fctm_pkg::MODE_NONE;
            n.host_run   = 1'b0;
            n.warn_thr   = fctm_pkg::WARN_RST;
            n.eef_ok     = 1'b1;
         end
      end
      // trip timer saturates at the hold time
      if (s.tripped && s.tmr < P_HOLD_CYC) begin
         n.tmr = s.tmr + 24'h1;
      end
      if (rst_req && s.tripped && !rst_ok) begin
         ev[fctm_pkg::IRQ_REFUS] = 1'b1;
      end
      if (accept) begin
         n.tripped = 1'b1;
         n.prio    = cand_prio;
         n.code    = cand_code;
         n.tmr     = 24'h0;
         n.eef_ok  = 1'b0;
         ev[fctm_pkg::IRQ_TRIP] = 1'b1;
         if (!s.tripped) begin
            n.frz = live;
         end
      end else if (clr) begin
         n.tripped = 1'b0;
         n.rearm   = 1'b1;
      end
      // run condition of the settings that stand after this cycle
      case (n.mode)
         fctm_pkg::MODE_SOLO:   run_cond = n.enable;
         fctm_pkg::MODE_HOST:   run_cond = n.enable && n.host_run;
         fctm_pkg::MODE_LEGACY: run_cond = n.enable && ribbon_s;
         default:               run_cond = 1'b0;
      endcase
      if (!run_cond) begin
         n.rearm = 1'b0;
      end
      // alarms run regardless of trip state
      n.alarm_hot  = i_heatsink_temp >= s.warn_thr;
      n.alarm_link = !link_s;
      ev[fctm_pkg::IRQ_HOT]  = n.alarm_hot;
      ev[fctm_pkg::IRQ_LINK] = n.alarm_link;
      n.irq_st = (s.irq_st & ~w1c) | ev;
      n.irq    = |(n.irq_st & n.irq_mask);
      // indications
      n.field_en = !n.tripped && run_cond && !n.rearm;
      if (n.tripped) begin
         n.left  = fctm_pkg::LEFT_TRIP;
         n.right = n.code;
      end else begin
         n.right = 8'h0;
         if (!n.enable) begin
            n.left = fctm_pkg::LEFT_INH;
         end else if (n.field_en) begin
            n.left = fctm_pkg::LEFT_RUN;
         end else begin
            n.left = fctm_pkg::LEFT_IDLE;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s          <= '0;
         s.awready  <= 1'b1;
         s.wready   <= 1'b1;
         s.arready  <= 1'b1;
         s.warn_thr <= fctm_pkg::WARN_RST;
         s.left     <= fctm_pkg::LEFT_INH;
      end else if (i_ce) begin
         s <= n;
      end
   end

   assign o_awready              = s.awready;
   assign o_wready               = s.wready;
   assign o_bvalid               = s.bvalid;
   assign o_bresp                = s.bresp;
   assign o_arready              = s.arready;
   assign o_rvalid               = s.rvalid;
   assign o_rdata                = s.rdata;
   assign o_rresp                = s.rresp;
   assign o_field_en             = s.field_en;
   assign o_left_disp            = s.left;
   assign o_right_disp           = s.right;
   assign o_alarm_hot            = s.alarm_hot;
   assign o_alarm_fail           = s.alarm_fail;
   assign o_host_link_lost_alarm = s.alarm_link;
   assign o_irq                  = s.irq;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_trip_taken;
      i_ce && accept;
   endsequence

   a_trip_gate: assert property (
      (i_ce && s.tripped && cand_v && cand_prio >= s.prio) |=> s.code == $past(s.code))
      else $error("lower ranked trip replaced the active one");
   a_hw_sticky: assert property (
      (s.tripped && s.prio == fctm_pkg::PRIO_HW) |=> s.tripped && !o_field_en)
      else $error("hardware fault trip was cleared");
   a_uv_self_clear: assert property (
      (i_ce && s.tripped && s.prio == fctm_pkg::PRIO_UV && supply_s && !accept) |=> !s.tripped)
      else $error("undervoltage trip did not clear itself");
   a_eef_locked: assert property (
      (s.tripped && s.prio == fctm_pkg::PRIO_EEF && !s.eef_ok && !def_req) |=> s.tripped)
      else $error("stored data trip cleared without defaults code");
   a_norm_reset: assert property (
      (i_ce && rst_req && s.tripped && s.prio == fctm_pkg::PRIO_NORM && s.tmr >= P_HOLD_CYC
       && !accept) |=> !s.tripped)
      else $error("normal trip refused a reset after the hold time");
   a_hold_window: assert property (
      (rst_req && s.tripped && s.tmr < P_HOLD_CYC && s.prio != fctm_pkg::PRIO_UV) |=> s.tripped)
      else $error("reset accepted inside the hold window");
   a_hot_alarm: assert property (
      (i_ce && i_heatsink_temp >= s.warn_thr) |=> o_alarm_hot)
      else $error("heatsink warning missing");
   a_def_fail: assert property (
      (i_ce && def_req && s.enable) |=> o_alarm_fail && s.enable && s.mode == $past(s.mode))
      else $error("defaults loaded while enabled");
   a_link_alarm: assert property (
      (i_ce && !link_s) |=> o_host_link_lost_alarm)
      else $error("link lost alarm missing");
   a_inhibit_disp: assert property (
      (o_left_disp == fctm_pkg::LEFT_INH) |-> (!s.enable && !s.tripped))
      else $error("inhibited shown while enabled or tripped");
   a_trip_disp: assert property (
      s_trip_taken |=> (o_left_disp == fctm_pkg::LEFT_TRIP) && (o_right_disp == $past(cand_code)))
      else $error("trip indication wrong");
   a_run_disp: assert property (
      (o_left_disp == fctm_pkg::LEFT_RUN) |-> (s.enable && s.mode != fctm_pkg::MODE_NONE))
      else $error("running shown without a selected mode");
   a_trip_disable: assert property (
      s_trip_taken |=> !o_field_en)
      else $error("field output still on after a trip");
   a_diag_frozen: assert property (
      (i_ce && s.tripped && !clr) |=> $stable(s.frz))
      else $error("frozen diagnostics changed while tripped");
   a_rearm_wait: assert property (
      (i_ce && clr) |=> !s.tripped && !o_field_en)
      else $error("output came back on in the clearing cycle");
endmodule : fctm_trip_mgr

// ===== hdl/fctm_pkg.sv
// constants and types shared by the field controller trip manager
package fctm_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_CODE  = 8'h04;
   localparam logic [7:0] REG_CMD   = 8'h08;
   localparam logic [7:0] REG_STAT  = 8'h0C;
   localparam logic [7:0] REG_IRQ   = 8'h10;
   localparam logic [7:0] REG_MASK  = 8'h14;
   localparam logic [7:0] REG_HIST  = 8'h18;
   localparam logic [7:0] REG_WARN  = 8'h1C;
   localparam logic [7:0] REG_DIAG0 = 8'h20;
   localparam logic [7:0] REG_DIAG4 = 8'h30;
   // field positions
   localparam int CTRL_EN   = 0;
   localparam int CTRL_MODE = 1;
   localparam int CTRL_HRUN = 3;
   localparam int CMD_RESET = 0;
   localparam int IRQ_TRIP  = 0;
   localparam int IRQ_HOT   = 1;
   localparam int IRQ_FAIL  = 2;
   localparam int IRQ_LINK  = 3;
   localparam int IRQ_REFUS = 4;
   localparam int NUM_IRQ   = 5;
   // modes of the mode parameter
   localparam logic [1:0] MODE_NONE   = 2'h0;
   localparam logic [1:0] MODE_SOLO   = 2'h1;
   localparam logic [1:0] MODE_HOST   = 2'h2;
   localparam logic [1:0] MODE_LEGACY = 2'h3;
   // trip priority categories
   localparam logic [2:0] PRIO_HW   = 3'h1;
   localparam logic [2:0] PRIO_UV   = 3'h2;
   localparam logic [2:0] PRIO_NRST = 3'h3;
   localparam logic [2:0] PRIO_EEF  = 3'h4;
   localparam logic [2:0] PRIO_NORM = 3'h5;
   localparam logic [7:0] CODE_UV       = 8'h01;
   localparam logic [7:0] CODE_DEFAULTS = 8'h0A;
   // reset values, synchroniser width and response codes
   localparam logic [7:0] WARN_RST = 8'hC8;
   localparam logic [2:0] SYNC_RST = 3'h6;
   localparam int         SYNC_W   = 3;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // timing
   localparam int          CLK_HZ       = 10000000;
   localparam int          TRIP_HOLD_MS = 1000;
   localparam logic [23:0] HOLD_CYC     = 24'(TRIP_HOLD_MS * (CLK_HZ / 1000));

   typedef enum logic [1:0] {LEFT_IDLE, LEFT_INH, LEFT_TRIP, LEFT_RUN} fctm_left_t;

   typedef struct packed {
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic [7:0]       awaddr;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic             enable;
      logic [1:0]       mode;
      logic             host_run;
      logic [7:0]       warn_thr;
      logic             tripped;
      logic [2:0]       prio;
      logic [7:0]       code;
      logic [23:0]      tmr;
      logic             eef_ok;
      logic             rearm;
      logic [4:0][15:0] frz;
      logic             alarm_hot;
      logic             alarm_fail;
      logic             alarm_link;
      logic [4:0]       irq_st;
      logic [4:0]       irq_mask;
      logic             irq;
      logic             field_en;
      fctm_left_t       left;
      logic [7:0]       right;
   } fctm_state_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
   } fctm_sync_t;

   typedef struct packed {
      logic [3:0][7:0] ent;
   } fctm_hist_t;
endpackage : fctm_pkg

// ===== hdl/fctm_sync.sv
// two-stage synchroniser for the asynchronous status pins
module fctm_sync (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_ce,
   input  wire logic [fctm_pkg::SYNC_W-1:0] i_pin,
   output logic      [fctm_pkg::SYNC_W-1:0] o_sync
);
   fctm_pkg::fctm_sync_t s_q;
   fctm_pkg::fctm_sync_t s_d;

   always_comb begin
      s_d    = s_q;
      s_d.s1 = i_pin;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q.s1 <= fctm_pkg::SYNC_RST;
         s_q.s2 <= fctm_pkg::SYNC_RST;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_sync = s_q.s2;
endmodule : fctm_sync

// ===== hdl/fctm_hist.sv
// four-entry trip history, entry 0 newest
module fctm_hist (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_push,
   input  wire logic [7:0]  i_code,
   output logic      [31:0] o_hist
);
   fctm_pkg::fctm_hist_t s_q;
   fctm_pkg::fctm_hist_t s_d;

   always_comb begin
      s_d = s_q;
      if (i_push) begin
         s_d.ent = {s_q.ent[2:0], i_code};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_hist = s_q.ent;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_hist_shift: assert property (
      (i_ce && i_push) |=> (o_hist[7:0] == $past(i_code)) && (o_hist[31:8] == $past(o_hist[23:0])))
      else $error("history did not shift in the new trip code");
   a_hist_hold: assert property (
      (!(i_ce && i_push)) |=> $stable(o_hist))
      else $error("history changed without a trip");
endmodule : fctm_hist

// ===== dv/fctm_host.sv
// behavioural host drive: supply, host link and ribbon status pins
module fctm_host (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_supply_cmd,
   input  wire logic i_link_cmd,
   output logic      o_supply_ok,
   output logic      o_host_link_ok,
   output logic      o_ribbon_conn
);
   timeunit 1ns;
   timeprecision 1ns;
   // pins change only just after an edge, like the real drive outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {o_supply_ok, o_host_link_ok, o_ribbon_conn} <= 3'b110;
      end else begin
         {o_supply_ok, o_host_link_ok, o_ribbon_conn} <= {i_supply_cmd, i_link_cmd, 1'b0};
      end
   end
endmodule : fctm_host

// ===== dv/fctm_trip_mgr_tb.sv
// self-checking bench for the trip manager
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fctm_trip_mgr_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, tv = 0;
   logic        sc = 1, lc = 1, awr, wr_r, bv, arr, rv, sok, lok, rib;
   logic        fen, hot, fl, lnk, irq;
   logic [1:0]  br, rr, ld;
   logic [2:0]  tp = 3'h5;
   logic [7:0]  aa = 8'h00, ara = 8'h00, tc = 8'h00, tmp = 8'h00, c1, c2, c3, rdp;
   logic [15:0] dg = 16'h0000, d0;
   logic [31:0] wd = 32'h0, rdat;
   logic [65:0] e, q[$];
   int          n_mismatch = 0, samples_checked = 0, seed = 32'h4B75;
   initial begin
      forever #50 clk = ~clk;
   end
   fctm_host host (.i_clk(clk), .i_rst_n(rst_n), .i_supply_cmd(sc), .i_link_cmd(lc),
      .o_supply_ok(sok), .o_host_link_ok(lok), .o_ribbon_conn(rib));
   fctm_trip_mgr #(.P_HOLD_CYC(24'd20)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
      .i_awvalid(awv), .o_awready(awr), .i_awaddr(aa), .i_wvalid(wv), .o_wready(wr_r),
      .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(bre), .o_bresp(br),
      .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rre),
      .o_rdata(rdat), .o_rresp(rr), .i_trip_valid(tv), .i_trip_prio(tp), .i_trip_code(tc),
      .i_supply_ok(sok), .i_host_link_ok(lok), .i_ribbon_conn(rib), .i_heatsink_temp(tmp),
      .i_diag_arm_v(dg), .i_diag_flux_fb(~dg), .i_diag_field_i(dg), .i_diag_fire_ang(~dg),
      .i_diag_flux_ref(dg), .o_field_en(fen), .o_left_disp(ld), .o_right_disp(rdp),
      .o_alarm_hot(hot), .o_alarm_fail(fl), .o_host_link_lost_alarm(lnk), .o_irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ha, hw, hb;
      @(posedge clk);
      {aa, wd, awv, wv, bre} <= {a, d, 3'b111};
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         {ha, hw, hb} = {awv & awr, wv & wr_r, bv};
         @(posedge clk);
         {awv, wv} <= {awv & ~ha, wv & ~hw};
         if (hb) break;
      end
      bre <= 1'b0;
      if (n == 40) begin n_mismatch++; wrap_up(); end
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFFFFFF,
           input logic [1:0] r = 2'h0);
      int n;
      logic ha, hr;
      @(posedge clk);
      q.push_back({r, m, x});
      {ara, arv, rre} <= {a, 2'b11};
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         {ha, hr} = {arv & arr, rv};
         @(posedge clk);
         arv <= arv & ~ha;
         if (hr) break;
      end
      rre <= 1'b0;
      if (n == 40) begin n_mismatch++; wrap_up(); end
   endtask : rd
   task trp(input logic [2:0] p, input logic [7:0] c);
      @(posedge clk);
      {tv, tp, tc} <= {1'b1, p, c};
      @(posedge clk);
      tv <= 1'b0;
   endtask : trp
   // output pins: irq, link lost, fail, hot, field enable, left, right
   task pins(input logic [14:0] x);
      @(negedge clk);
      `CK({irq, lnk, fl, hot, fen, ld, rdp}, x)
   endtask : pins
   function automatic logic [31:0] st(logic t, logic [2:0] p, logic [7:0] c, logic [1:0] l);
      return {17'h0, l, 1'b0, c, p, t};
   endfunction : st
   // takes the oldest note whenever read data is handed over
   always @(negedge clk) begin
      if (rv === 1'b1 && rre === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         `CK({rr, rdat & e[63:32]}, {e[65:64], e[31:0]})
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      c1 = 8'($random(seed));
      c2 = 8'($random(seed));
      c3 = 8'($random(seed));
      cyc(10);
      rst_n <= 1'b1;
      rd(fctm_pkg::REG_WARN, 32'hC8);
      rd(fctm_pkg::REG_MASK, 32'h0);
      rd(8'h40, 32'h0, 32'hFFFFFFFF, fctm_pkg::RESP_ERR);
      rd(fctm_pkg::REG_STAT, st(0, 0, 0, 1), 32'h6001);
      pins({5'h00, 2'h1, 8'h00});
      wr(fctm_pkg::REG_CTRL, 32'h3);
      wr(fctm_pkg::REG_MASK, 32'h1F);
      cyc(4);
      rd(fctm_pkg::REG_STAT, 32'h7000, 32'h7001);
      pins({5'h01, 2'h3, 8'h00});
      dg <= 16'($random(seed));
      trp(fctm_pkg::PRIO_NORM, c1);
      d0 = dg;
      dg <= dg + 16'h1;
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, st(1, 5, c1, 2), 32'h7FFF);
      rd(fctm_pkg::REG_IRQ, 32'h11, 32'h11);
      pins({5'h10, 2'h2, c1});
      rd(fctm_pkg::REG_DIAG0, {16'h0, d0});
      cyc(20);
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, 32'h0, 32'h1001);
      rd(fctm_pkg::REG_DIAG0, {16'h0, dg});
      trp(fctm_pkg::PRIO_NORM, c2);
      trp(fctm_pkg::PRIO_HW, c3);
      trp(fctm_pkg::PRIO_NORM, ~c3);
      rd(fctm_pkg::REG_STAT, st(1, 1, c3, 2), 32'h7FFF);
      rd(fctm_pkg::REG_HIST, {8'h0, c1, c2, c3});
      cyc(20);
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, st(1, 1, c3, 2), 32'h7FFF);
      pins({5'h10, 2'h2, c3});
      wr(fctm_pkg::REG_IRQ, 32'h1F);
      rd(fctm_pkg::REG_IRQ, 32'h0);
      pins({5'h00, 2'h2, c3});
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      wr(fctm_pkg::REG_CTRL, 32'h1);
      trp(fctm_pkg::PRIO_EEF, c1);
      wr(fctm_pkg::REG_CODE, 32'h0A);
      rd(fctm_pkg::REG_STAT, 32'h10001, 32'h10001);
      pins({5'h04, 2'h2, c1});
      wr(fctm_pkg::REG_CTRL, 32'h0);
      cyc(20);
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, 32'h1, 32'h1);
      wr(fctm_pkg::REG_CODE, 32'h0A);
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, 32'h0, 32'h10001);
      sc <= 1'b0;
      cyc(6);
      rd(fctm_pkg::REG_STAT, st(1, 2, 8'h01, 2), 32'h7FFF);
      wr(fctm_pkg::REG_CMD, 32'h1);
      rd(fctm_pkg::REG_STAT, 32'h1, 32'h1);
      sc <= 1'b1;
      cyc(6);
      rd(fctm_pkg::REG_STAT, 32'h0, 32'h1);
      {lc, tmp} <= {1'b0, 8'hC8};
      cyc(6);
      rd(fctm_pkg::REG_STAT, 32'h28000, 32'h28000);
      pins({5'h0A, 2'h1, 8'h00});
      wrap_up();
   end
endmodule : fctm_trip_mgr_tb
